// File: ndf_diag_flags.sv
// Purpose: diagnostic status flags of a token bus network core, APB slave
// Assumes: event inputs are one-cycle pulses from the protocol engine on pclk
// Notes:   receive_input_line is a pin and is synchronised
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ndf_diag_flags (
  input  wire logic        pclk,                // core clock, 50 MHz
  input  wire logic        presetn,             // asynchronous reset, active low
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb access phase
  input  wire logic        pwrite,              // apb write
  input  wire logic [7:0]  paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic [31:0]      prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // apb error, unmapped address
  input  wire logic        receive_input_line,  // network receive pin
  input  wire logic        lost_token_timeout,  // pulse: lost token timer expired
  input  wire logic        line_idle_timeout,   // pulse: line idle timer expired
  input  wire logic        token_done,          // pulse: token frame ended
  input  wire logic [7:0]  token_did1,          // first destination identity
  input  wire logic [7:0]  token_did2,          // second destination identity
  input  wire logic        token_eot_ok,        // end of transmission verified
  input  wire logic        token_zeros_ok,      // trailing zeros verified
  input  wire logic        token_answered,      // a response followed the token
  input  wire logic        token_from_self,     // token sent by this node
  input  wire logic        token_for_self,      // this node received the token
  input  wire logic        refusal,             // pulse: enquiry refused
  input  wire logic        successor_update,    // pulse: next identity changed
  input  wire logic [7:0]  successor_id,        // new next identity
  output logic             irq                  // level interrupt, active high
);

  logic [7:0] flags;         // diagnostic flags
  logic [7:0] next_flags;    // next diagnostic flags
  logic [7:0] set_ev;        // set pulses per flag
  logic [7:0] mask;          // interrupt_mask_register
  logic [7:0] events;        // sticky events
  logic [7:0] ctrl;          // control bits
  logic [7:0] node_id;       // own identity
  logic [7:0] probe_id;      // tentative identity
  logic [7:0] successor;     // next identity
  logic       reconfig;      // reconfiguration_flag
  logic       rx_level;      // synchronised receive line
  logic       excess_hit;    // refusal limit reached
  logic       setup;         // apb setup cycle
  logic       wr_acc;        // apb write access
  logic       rd_acc;        // apb read access
  logic       mapped;        // address decodes
  logic       clr_cmd;       // clear flags command written
  logic       dup_match;     // duplicate identity seen
  logic       probe_match;   // probe identity answered
  logic [7:0] read_mux;      // read value

  // bus phases
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;

  // address decode
  always_comb begin
    case (paddr)
      ndf_pkg::ADDR_DIAG, ndf_pkg::ADDR_MASK, ndf_pkg::ADDR_EVENT,
      ndf_pkg::ADDR_CTRL, ndf_pkg::ADDR_NODE_ID, ndf_pkg::ADDR_PROBE_ID,
      ndf_pkg::ADDR_SUCCESSOR, ndf_pkg::ADDR_MAIN_STATUS,
      ndf_pkg::ADDR_COMMAND: mapped = 1'b1;
      default:               mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // receive pin through two flip-flops
  ndf_sync u_rx_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (receive_input_line),
    .q     (rx_level)
  );

  // refusal counting
  ndf_refusal_counter u_refusals (
    .clk       (pclk),
    .rst_n     (presetn),
    .refusal   (refusal),
    .clear     (clr_cmd),
    .short_sel (ctrl[ndf_pkg::BIT_SHORT_LIM]),
    .hit       (excess_hit)
  );

  // clear flags command
  assign clr_cmd = wr_acc && paddr == ndf_pkg::ADDR_COMMAND
                   && pwdata[7:0] == ndf_pkg::CMD_CLEAR_FLAGS;

  // token checks
  assign dup_match = token_done && token_answered && token_eot_ok && token_zeros_ok
                     && token_did1 == node_id && token_did2 == node_id;
  assign probe_match = token_done && token_answered && token_eot_ok
                       && token_did1 == probe_id;

  // set pulses per flag
  always_comb begin
    set_ev                          = 8'h00;
    set_ev[ndf_pkg::BIT_SELF_RECONFIGURATION_FLAG] = lost_token_timeout;
    set_ev[ndf_pkg::BIT_DUPLICATE]  = dup_match
      || (ctrl[ndf_pkg::BIT_TX_ON] && token_for_self);
    set_ev[ndf_pkg::BIT_ACTIVITY]   = rx_level;
    set_ev[ndf_pkg::BIT_TOKEN_SEEN] = token_done && !token_from_self;
    set_ev[ndf_pkg::BIT_EXCESS]     = excess_hit;
    set_ev[ndf_pkg::BIT_PROBE]      = probe_match;
    set_ev[ndf_pkg::BIT_SUCCESSOR]  = successor_update;
  end

  // flag next state; a set always wins over a clear
  always_comb begin
    next_flags = flags;
    if (clr_cmd) begin
      // command clears everything except duplicate and successor
      next_flags[ndf_pkg::BIT_SELF_RECONFIGURATION_FLAG] = 1'b0;
      next_flags[ndf_pkg::BIT_ACTIVITY]   = 1'b0;
      next_flags[ndf_pkg::BIT_TOKEN_SEEN] = 1'b0;
      next_flags[ndf_pkg::BIT_EXCESS]     = 1'b0;
      next_flags[ndf_pkg::BIT_PROBE]      = 1'b0;
    end
    if (rd_acc && paddr == ndf_pkg::ADDR_DIAG) begin
      next_flags[ndf_pkg::BIT_DUPLICATE] = 1'b0;
    end
    if (rd_acc && paddr == ndf_pkg::ADDR_SUCCESSOR) begin
      next_flags[ndf_pkg::BIT_SUCCESSOR] = 1'b0;
    end
    next_flags = (next_flags | set_ev) & ndf_pkg::DIAG_USED_BITS;
  end

  // diagnostic flags; of the bus writes only the clear command reaches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= ndf_pkg::RESET_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events <= ndf_pkg::RESET_FLAGS;
    end else if (wr_acc && paddr == ndf_pkg::ADDR_EVENT) begin
      events <= (events & ~pwdata[7:0]) | set_ev;
    end else begin
      events <= events | set_ev;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask     <= ndf_pkg::RESET_MASK;
      ctrl     <= ndf_pkg::RESET_CTRL;
      node_id  <= ndf_pkg::RESET_ID;
      probe_id <= ndf_pkg::RESET_ID;
    end else if (wr_acc) begin
      case (paddr)
        ndf_pkg::ADDR_MASK:     mask     <= pwdata[7:0];
        ndf_pkg::ADDR_CTRL:     ctrl     <= pwdata[7:0];
        ndf_pkg::ADDR_NODE_ID:  node_id  <= pwdata[7:0];
        ndf_pkg::ADDR_PROBE_ID: probe_id <= pwdata[7:0];
        default:                ;  // read-only, written in other blocks, or unmapped
      endcase
    end
  end

  // next identity held from the protocol engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      successor <= ndf_pkg::RESET_ID;
    end else if (successor_update) begin
      successor <= successor_id;
    end
  end

  // main reconfiguration flag, set wins over the clear command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reconfig <= 1'b0;
    end else if (line_idle_timeout) begin
      reconfig <= 1'b1;
    end else if (clr_cmd) begin
      reconfig <= 1'b0;
    end
  end

  // read value selection
  always_comb begin
    read_mux = 8'h00;
    case (paddr)
      ndf_pkg::ADDR_DIAG:        read_mux = flags;
      ndf_pkg::ADDR_MASK:        read_mux = mask;
      ndf_pkg::ADDR_EVENT:       read_mux = events;
      ndf_pkg::ADDR_CTRL:        read_mux = ctrl;
      ndf_pkg::ADDR_NODE_ID:     read_mux = node_id;
      ndf_pkg::ADDR_PROBE_ID:    read_mux = probe_id;
      ndf_pkg::ADDR_SUCCESSOR:   read_mux = successor;
      ndf_pkg::ADDR_MAIN_STATUS: read_mux[ndf_pkg::BIT_RECONFIG] = reconfig;
      default:                   read_mux = 8'h00;
    endcase
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= {24'h00_0000, read_mux};
    end
  end

  // interrupt: level flags and sticky events through one mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(mask & ((next_flags & ndf_pkg::LEVEL_IRQ_BITS)
                | ((events | set_ev) & ~ndf_pkg::LEVEL_IRQ_BITS)));
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // helper count of refusals since the last clear, kept apart from the counter
  logic [7:0] chk_refusals;   // refusals since clear, saturating
  logic       chk_short_used; // a refusal came under the short limit since clear

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_refusals   <= 8'h00;
      chk_short_used <= 1'b0;
    end else if (clr_cmd) begin
      chk_refusals   <= 8'h00;
      chk_short_used <= 1'b0;
    end else if (refusal) begin
      chk_refusals   <= chk_refusals + {7'h00, chk_refusals != 8'hff};
      chk_short_used <= chk_short_used || ctrl[ndf_pkg::BIT_SHORT_LIM];
    end
  end

  sequence s_rx_held;
    receive_input_line [*3];
  endsequence

  sequence s_diag_read;
    psel && penable && !pwrite && paddr == ndf_pkg::ADDR_DIAG;
  endsequence

  sequence s_short_last;
    ctrl[1] && refusal && !clr_cmd && chk_refusals == 8'(ndf_pkg::REFUSAL_SHORT_LIMIT - 1);
  endsequence

  sequence s_long_last;
    !ctrl[1] && refusal && !clr_cmd && !chk_short_used
      && chk_refusals == 8'(ndf_pkg::REFUSAL_LONG_LIMIT - 1);
  endsequence

  a_self_reconfiguration_flag_set: assert property (lost_token_timeout |=> flags[7])
    else $error("self reconfiguration flag not set");
  a_dup_match_set: assert property (dup_match |=> flags[6])
    else $error("duplicate flag not set on matching token");
  a_dup_online_set: assert property (ctrl[0] && token_for_self |=> flags[6])
    else $error("duplicate flag not set while on line");
  a_dup_read_clear: assert property (s_diag_read ##0 !set_ev[6] |=> !flags[6])
    else $error("duplicate flag not cleared by status read");
  a_activity_set: assert property (s_rx_held |=> flags[5])
    else $error("activity flag not set after line high");
  a_token_seen_set: assert property (token_done && !token_from_self |=> flags[4])
    else $error("token seen flag not set");
  a_excess_short: assert property (s_short_last |-> ##2 flags[3])
    else $error("excess flag not set after short limit");
  a_excess_long: assert property (s_long_last |-> ##2 flags[3])
    else $error("excess flag not set after long limit");
  a_excess_hold: assert property (flags[3] && !clr_cmd |=> flags[3])
    else $error("excess flag cleared without clear command");
  a_irq_level: assert property (|(flags & mask & 8'h0a) |=> irq || $past(clr_cmd)
      || $past(rd_acc))
    else $error("interrupt missing for masked-in flag");
  a_probe_set: assert property (probe_match |=> flags[2])
    else $error("probe flag not set");
  a_successor_rd: assert property (
      rd_acc && paddr == ndf_pkg::ADDR_SUCCESSOR && !successor_update |=> !flags[1])
    else $error("successor flag not cleared by read");
  a_reserved_low: assert property (!flags[0])
    else $error("reserved bit is set");
  a_reconfig_set: assert property (line_idle_timeout |=> reconfig)
    else $error("reconfiguration flag not set");
  a_diag_write: assert property (wr_acc && paddr == ndf_pkg::ADDR_DIAG && set_ev == 8'h00
      && !clr_cmd && !rd_acc |=> flags == $past(flags))
    else $error("write changed diagnostic flags");

endmodule
`default_nettype wire

// File: ndf_net_model.sv
// Purpose: far-side model that makes network events and the receive line level
// Assumes: driven through its tasks; every change lands just after a rising edge
// Notes:   released token fields show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module ndf_net_model (
  input  wire logic  clk,       // core clock
  output logic       rx_line,   // receive line level
  output logic [4:0] ev,        // pulses: lost, idle, refusal, successor, own token
  output logic [7:0] succ_id,   // successor identity
  output logic       tok_done,  // token frame ended
  output logic [7:0] did1,      // first destination identity
  output logic [7:0] did2,      // second destination identity
  output logic [3:0] tok_q      // eot ok, zeros ok, answered, from self
);
  // quiet network at time zero
  initial begin
    rx_line = 1'b0;
    ev = 5'h00;
    succ_id = 8'h00;
    tok_done = 1'b0;
    did1 = 8'h00;
    did2 = 8'h00;
    tok_q = 4'h0;
  end
  // one-cycle event pulse; id matters only for successor updates
  task automatic pulse(input int k, input logic [7:0] id);
    @(posedge clk);
    ev <= 5'h01 << k;
    succ_id <= id;
    @(posedge clk);
    ev <= 5'h00;
    succ_id <= ~id;  // released
  endtask
  // end of one token frame with its qualifiers
  task automatic token(input logic [7:0] a, input logic [7:0] b, input logic [3:0] q);
    @(posedge clk);
    tok_done <= 1'b1;
    did1 <= a;
    did2 <= b;
    tok_q <= q;
    @(posedge clk);
    tok_done <= 1'b0;
    did1 <= ~a;  // released
    did2 <= ~b;
    tok_q <= ~q;
  endtask
  // receive line high for n cycles, then idle low
  task automatic burst(input int n);
    @(posedge clk);
    rx_line <= 1'b1;
    repeat (n) @(posedge clk);
    rx_line <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: ndf_pkg.sv
// Purpose: shared constants of the network diagnostic flag block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   all offsets are byte addresses
package ndf_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_DIAG        = 8'h00; // diagnostic flags, read only
  localparam logic [7:0] ADDR_MASK        = 8'h04; // interrupt_mask_register
  localparam logic [7:0] ADDR_EVENT       = 8'h08; // sticky event bits, write one to clear
  localparam logic [7:0] ADDR_CTRL        = 8'h0c; // control bits
  localparam logic [7:0] ADDR_NODE_ID     = 8'h10; // this node's identity
  localparam logic [7:0] ADDR_PROBE_ID    = 8'h14; // tentative identity to probe for
  localparam logic [7:0] ADDR_SUCCESSOR   = 8'h18; // next identity, read clears bit 1
  localparam logic [7:0] ADDR_MAIN_STATUS = 8'h1c; // main status, reconfiguration bit
  localparam logic [7:0] ADDR_COMMAND     = 8'h20; // command, write only

  // diagnostic flag bit positions
  localparam int BIT_SELF_RECONFIGURATION_FLAG = 7; // self_caused_reconfig_flag
  localparam int BIT_DUPLICATE  = 6; // duplicate_node_flag
  localparam int BIT_ACTIVITY   = 5; // line_activity_flag
  localparam int BIT_TOKEN_SEEN = 4; // token seen from another node
  localparam int BIT_EXCESS     = 3; // excess_refusal_flag
  localparam int BIT_PROBE      = 2; // probe_identity_match_flag
  localparam int BIT_SUCCESSOR  = 1; // successor_changed_flag

  // main status and control bit positions
  localparam int BIT_RECONFIG   = 2; // reconfiguration_flag in main status
  localparam int BIT_TX_ON      = 0; // control: transmitter on, node on line
  localparam int BIT_SHORT_LIM  = 1; // control: use the short refusal limit

  // flags that drive the interrupt as levels through the mask
  localparam logic [7:0] LEVEL_IRQ_BITS = 8'h0a;
  // bits that exist in the diagnostic register (low bit reserved)
  localparam logic [7:0] DIAG_USED_BITS = 8'hfe;

  // reset values
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  localparam logic [7:0] RESET_MASK  = 8'h00;
  localparam logic [7:0] RESET_CTRL  = 8'h00;
  localparam logic [7:0] RESET_ID    = 8'h00;

  // command that clears the diagnostic flags other than duplicate and successor, and the reconfiguration flag
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h1e;

  // refusal counts that raise the excess flag
  localparam int REFUSAL_LONG_LIMIT  = 128;
  localparam int REFUSAL_SHORT_LIMIT = 4;

endpackage

// File: ndf_refusal_counter.sv
// Purpose: counts refusals to free buffer enquiries
// Assumes: refusal is a one-cycle pulse on clk
// Notes:   hit pulses once when the chosen limit is reached
`timescale 1ns/1ns
`default_nettype none
module ndf_refusal_counter #(
  parameter int WIDTH       = 8,                              // counter width
  parameter int LONG_LIMIT  = ndf_pkg::REFUSAL_LONG_LIMIT,    // long limit
  parameter int SHORT_LIMIT = ndf_pkg::REFUSAL_SHORT_LIMIT    // short limit
) (
  input  wire logic clk,        // core clock
  input  wire logic rst_n,      // asynchronous reset, active low
  input  wire logic refusal,    // one refusal seen
  input  wire logic clear,      // restart counting
  input  wire logic short_sel,  // select the short limit
  output logic      hit         // pulse: limit reached
);

  logic [WIDTH-1:0] count;      // refusals so far
  logic [WIDTH-1:0] limit;      // active limit

  // refuse limits that the counter cannot reach
  if (LONG_LIMIT >= (1 << WIDTH) || SHORT_LIMIT >= (1 << WIDTH)
      || SHORT_LIMIT < 1 || LONG_LIMIT < 1) begin : g_bad_limits
    $error("ndf_refusal_counter: limits do not fit WIDTH");
  end

  // pick the limit
  assign limit = short_sel ? WIDTH'(SHORT_LIMIT) : WIDTH'(LONG_LIMIT);

  // count refusals, restart at the limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      hit   <= 1'b0;
    end else if (clear) begin
      count <= '0;
      hit   <= 1'b0;
    end else if (refusal && (count + 1'b1) >= limit) begin
      count <= '0;   // limit reached
      hit   <= 1'b1;
    end else begin
      count <= refusal ? count + 1'b1 : count;
      hit   <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: ndf_sync.sv
// Purpose: two-stage synchroniser for one pin level
// Assumes: d is asynchronous to clk
// Notes:   only the second stage is visible outside
`timescale 1ns/1ns
`default_nettype none
module ndf_sync (
  input  wire logic clk,     // core clock
  input  wire logic rst_n,   // asynchronous reset, active low
  input  wire logic d,       // asynchronous level
  output logic      q        // synchronised level
);

  logic meta; // first stage, read only by q

  // two flip-flops in series
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
`default_nettype wire

// File: tb_network_diagnostic_status_flags.sv
// Purpose: self-checking bench for the diagnostic flag block
// Assumes: apb slave answers when it will, flags visible a few edges after each event
// Notes:   reads queue their expectation; a monitor compares at the access edge
`timescale 1ns/1ns
`default_nettype none
module tb_network_diagnostic_status_flags;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} ndf_exp_t;
  logic        pclk, presetn, psel, penable, pwrite;  // clock, reset, apb control
  logic [7:0]  paddr;                                 // apb address
  logic [31:0] pwdata, prdata;                        // apb data
  logic        pready, pslverr, irq;                  // slave answers
  logic        rx, tdone;                             // partner line and frame end
  logic [4:0]  ev;                                    // partner pulses
  logic [7:0]  sidw, d1, d2, nid, pid, sid;           // identities
  logic [3:0]  tq;                                    // token qualifiers
  logic [31:0] lfsr;                                  // random state
  ndf_exp_t    exp_q[$];                              // pending read results
  int          fails, checks;                         // counters
  ndf_diag_flags u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .receive_input_line(rx), .lost_token_timeout(ev[0]),
    .line_idle_timeout(ev[1]), .token_done(tdone), .token_did1(d1), .token_did2(d2),
    .token_eot_ok(tq[3]), .token_zeros_ok(tq[2]), .token_answered(tq[1]),
    .token_from_self(tq[0]), .token_for_self(ev[4]), .refusal(ev[2]),
    .successor_update(ev[3]), .successor_id(sidw), .irq(irq));
  ndf_net_model u_net (.clk(pclk), .rx_line(rx), .ev(ev), .succ_id(sidw), .tok_done(tdone),
    .did1(d1), .did2(d2), .tok_q(tq));
  // free-running 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // random source
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read with expected value, compare mask and error flag
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er);
    exp_q.push_back('{e, m, er});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // compare one read result
  task automatic chk_rd(input ndf_exp_t x);
    checks++;
    if (((prdata ^ x.d) & x.m) !== 32'h0 || pslverr !== x.e) begin
      fails++;
      $display("ERROR %0t read got %h err %b exp %h", $time, prdata, pslverr, x.d);
    end
  endtask
  // compare the interrupt level
  task automatic chk_irq(input logic e);
    checks++;
    if (irq !== e) begin
      fails++;
      $display("ERROR %0t irq %b exp %b", $time, irq, e);
    end
  endtask
  // monitor: completed reads take the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("ERROR %0t read with nothing expected", $time);
      end else begin
        chk_rd(exp_q.pop_front());
      end
    end
  end
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out;
  end
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    checks = 0;
    lfsr = 32'hc418;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    lfsr = next_rand(lfsr);
    nid = lfsr[7:0];
    pid = nid ^ 8'h5a;
    lfsr = next_rand(lfsr);
    sid = lfsr[15:8];
    chk_irq(1'b0);
    rd(ndf_pkg::ADDR_DIAG, 32'h0, 32'hfffffffe, 1'b0);
    rd(ndf_pkg::ADDR_MASK, 32'h0, 32'hffffffff, 1'b0);
    rd(8'h40, 32'h0, 32'h0, 1'b1);
    wr(ndf_pkg::ADDR_DIAG, 32'hff);
    rd(ndf_pkg::ADDR_DIAG, 32'h0, 32'hfe, 1'b0);
    wr(ndf_pkg::ADDR_NODE_ID, {24'h0, nid});
    wr(ndf_pkg::ADDR_PROBE_ID, {24'h0, pid});
    // own token with bad trailing zeros: neither duplicate nor token seen
    u_net.token(nid, nid, 4'hb);
    wait_n(3);
    rd(ndf_pkg::ADDR_DIAG, 32'h0, 32'h74, 1'b0);
    u_net.token(nid, nid, 4'he);
    wait_n(3);
    rd(ndf_pkg::ADDR_DIAG, 32'h50, 32'h74, 1'b0);
    rd(ndf_pkg::ADDR_DIAG, 32'h10, 32'h74, 1'b0);
    u_net.token(pid, ~pid, 4'hb);
    wait_n(3);
    rd(ndf_pkg::ADDR_DIAG, 32'h14, 32'h74, 1'b0);
    wr(ndf_pkg::ADDR_CTRL, 32'h1);
    u_net.pulse(4, 8'h00);
    wait_n(3);
    rd(ndf_pkg::ADDR_DIAG, 32'h40, 32'h40, 1'b0);
    wr(ndf_pkg::ADDR_CTRL, 32'h2);
    u_net.pulse(0, 8'h00);
    u_net.pulse(1, 8'h00);
    wait_n(3);
    rd(ndf_pkg::ADDR_DIAG, 32'h80, 32'h80, 1'b0);
    rd(ndf_pkg::ADDR_MAIN_STATUS, 32'h4, 32'h4, 1'b0);
    u_net.burst(3);
    wait_n(5);
    rd(ndf_pkg::ADDR_DIAG, 32'h20, 32'h20, 1'b0);
    wr(ndf_pkg::ADDR_COMMAND, {24'h0, ndf_pkg::CMD_CLEAR_FLAGS});
    rd(ndf_pkg::ADDR_DIAG, 32'h0, 32'hbc, 1'b0);
    // short limit: three refusals stay quiet, the fourth sets the flag
    repeat (3) u_net.pulse(2, 8'h00);
    wait_n(4);
    rd(ndf_pkg::ADDR_DIAG, 32'h0, 32'h08, 1'b0);
    u_net.pulse(2, 8'h00);
    wait_n(4);
    rd(ndf_pkg::ADDR_DIAG, 32'h08, 32'h08, 1'b0);
    chk_irq(1'b0);
    wr(ndf_pkg::ADDR_MASK, 32'h08);
    wait_n(3);
    chk_irq(1'b1);
    rd(ndf_pkg::ADDR_DIAG, 32'h08, 32'h08, 1'b0);
    wr(ndf_pkg::ADDR_COMMAND, {24'h0, ndf_pkg::CMD_CLEAR_FLAGS});
    wait_n(3);
    rd(ndf_pkg::ADDR_DIAG, 32'h0, 32'h08, 1'b0);
    chk_irq(1'b0);
    // long limit: boundary at the 128th refusal
    wr(ndf_pkg::ADDR_CTRL, 32'h0);
    repeat (127) u_net.pulse(2, 8'h00);
    wait_n(4);
    rd(ndf_pkg::ADDR_DIAG, 32'h0, 32'h08, 1'b0);
    u_net.pulse(2, 8'h00);
    wait_n(4);
    rd(ndf_pkg::ADDR_DIAG, 32'h08, 32'h08, 1'b0);
    wr(ndf_pkg::ADDR_COMMAND, {24'h0, ndf_pkg::CMD_CLEAR_FLAGS});
    // successor change: survives a status read, cleared by the successor read
    wr(ndf_pkg::ADDR_MASK, 32'h02);
    u_net.pulse(3, sid);
    wait_n(3);
    chk_irq(1'b1);
    rd(ndf_pkg::ADDR_DIAG, 32'h02, 32'h0a, 1'b0);
    rd(ndf_pkg::ADDR_DIAG, 32'h02, 32'h02, 1'b0);
    rd(ndf_pkg::ADDR_SUCCESSOR, {24'h0, sid}, 32'hff, 1'b0);
    rd(ndf_pkg::ADDR_DIAG, 32'h0, 32'h02, 1'b0);
    wait_n(2);
    chk_irq(1'b0);
    // event bit raised through the mask, then cleared by writing one
    wr(ndf_pkg::ADDR_EVENT, 32'hff);
    wr(ndf_pkg::ADDR_MASK, 32'h80);
    wait_n(3);
    chk_irq(1'b0);
    u_net.pulse(0, 8'h00);
    wait_n(3);
    chk_irq(1'b1);
    rd(ndf_pkg::ADDR_EVENT, 32'h80, 32'h80, 1'b0);
    wr(ndf_pkg::ADDR_EVENT, 32'h80);
    wait_n(3);
    chk_irq(1'b0);
    wait_n(2);
    close_out;
  end
endmodule
`default_nettype wire
